// ### rtl/hrp_params.svh
// Purpose: Offsets, bit positions, codes and reset values of the host port
// Assumes: Byte wide I/O port, offsets relative to the card's base
// Notes: Definitions only
`ifndef HRP_PARAMS_SVH
`define HRP_PARAMS_SVH

`define HRP_OFF_STATUS 4'h1
`define HRP_OFF_TXDATA 4'h2
`define HRP_OFF_RXDATA 4'h3
`define HRP_OFF_ISR 4'h5
`define HRP_OFF_IER 4'h8

`define HRP_BIT_TX_EMPTY_N 4
`define HRP_BIT_RX_PEND_N 3
`define HRP_BIT_RX_FULL 2
`define HRP_BIT_STAT_PEND_N 1
`define HRP_BIT_STAT_FULL 0
`define HRP_RSVD_VAL 3'h0

`define HRP_CODE_OFF 3'h0
`define HRP_CODE_STAT_FULL 3'h1
`define HRP_CODE_STAT_PEND 3'h2
`define HRP_CODE_RX_FULL 3'h3
`define HRP_CODE_RX_PEND 3'h4
`define HRP_CODE_TX_EMPTY 3'h5
`define HRP_CODE_TDMA 3'h6
`define HRP_CODE_RDMA 3'h7

`define HRP_BYTE_RST 8'h00
`define HRP_CNT_RST 16'h0000
`define HRP_FIFO_DEPTH 32

`endif

// ### rtl/hrp_pkg.sv
// Purpose: Types shared by the host port files
// Assumes: Nothing beyond the params header
// Notes: Count width is fixed at 16 bits
package hrp_pkg;

   typedef enum logic {hrp_dma_idle, hrp_dma_run} hrp_dma_t;

   typedef struct packed {
      logic [7:0] data;
      logic last;
   } hrp_byte_t;

   typedef struct packed {
      logic rx_full;
      hrp_byte_t rx_byte;
      logic stat_full;
      logic [7:0] stat_data;
      logic tx_full;
      logic [7:0] tx_data;
      logic [2:0] ier_code;
      logic irq;
      hrp_dma_t dma;
      logic [15:0] dma_cnt;
      logic dma_valid;
      hrp_byte_t dma_out;
      logic dma_done;
      logic tx_dma_start;
      logic [7:0] rdata;
   } hrp_state_t;

endpackage

// ### rtl/hrp_fifo.sv
// Purpose: Receive byte FIFO between the network side and the data register
// Assumes: DEPTH is a power of two
// Notes: Ready and valid come from flops so both sides see clean levels
`timescale 1ns/100ps
module hrp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic full;
      logic empty;
   } hrp_fifo_st_t;

   hrp_fifo_st_t st_ff;
   hrp_fifo_st_t nxt_st;
   logic push;
   logic pop;

   always_comb begin
      nxt_st = st_ff;
      push = in_valid & ~st_ff.full;
      pop = out_ready & ~st_ff.empty;
      if (push) begin
         nxt_st.mem[st_ff.wp] = in_data;
         nxt_st.wp = st_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_st.rp = st_ff.rp + 1'b1;
      end
      if (push && !pop) begin
         nxt_st.cnt = st_ff.cnt + 1'b1;
      end else if (pop && !push) begin
         nxt_st.cnt = st_ff.cnt - 1'b1;
      end
      nxt_st.full = (nxt_st.cnt == DEPTH[AW:0]);
      nxt_st.empty = (nxt_st.cnt == '0);
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '{mem: '0, wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign in_ready = ~st_ff.full;
   assign out_valid = ~st_ff.empty;
   assign out_data = st_ff.mem[st_ff.rp];
endmodule

// ### rtl/hrp_port.sv
// Purpose: Host receive data port and interrupt status register of the card
// Assumes: Host strobes last one cycle; read data is valid the cycle after
// Notes: Status source waits while status_busy is high
`timescale 1ns/100ps
`include "hrp_params.svh"
module hrp_port #(
   parameter int FIFO_DEPTH = `HRP_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // Host I/O port
   input wire logic io_cs,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [3:0] io_addr,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic irq,
   // Received bytes from the network side
   input wire logic net_valid,
   input wire hrp_pkg::hrp_byte_t net_byte,
   output logic net_ready,
   // Status bytes from the command engine
   input wire logic stat_valid,
   input wire logic [7:0] stat_data,
   output logic status_busy,
   // Transmit byte to the transmit engine
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   output logic tx_dma_start,
   input wire logic tx_dma_done,
   // Receive DMA toward host memory
   input wire logic [15:0] rx_dma_count,
   output logic dma_valid,
   output hrp_pkg::hrp_byte_t dma_byte,
   input wire logic dma_ready
);
   hrp_pkg::hrp_state_t st_ff;
   hrp_pkg::hrp_state_t nxt_st;
   hrp_pkg::hrp_byte_t fifo_byte;
   logic fifo_valid;
   logic fifo_pop;
   logic rd;
   logic wr;
   logic rx_pend_n;
   logic stat_pend_n;
   logic irq_set;
   logic dma_end;
   logic [7:0] isr;

   // Buffer absorbs a frame burst while the host is slow to drain
   hrp_fifo #(
      .WIDTH($bits(hrp_pkg::hrp_byte_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .arst_n(arst_n),
      .in_valid(net_valid),
      .in_data(net_byte),
      .in_ready(net_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_byte),
      .out_ready(fifo_pop)
   );

   assign rd = io_cs & io_rd;
   assign wr = io_cs & io_wr;
   assign rx_pend_n = ~(st_ff.rx_full | fifo_valid);
   assign stat_pend_n = ~(st_ff.stat_full | stat_valid);
   assign dma_end = st_ff.dma_valid & dma_ready &
                    (st_ff.dma_out.last | (st_ff.dma_cnt == 16'h0001));
   // Reserved bits held at zero so later use stays compatible
   assign isr = {`HRP_RSVD_VAL, st_ff.tx_full, rx_pend_n, st_ff.rx_full,
                 stat_pend_n, st_ff.stat_full};

   always_comb begin
      nxt_st = st_ff;
      nxt_st.tx_dma_start = 1'b0;
      nxt_st.dma_done = 1'b0;
      fifo_pop = 1'b0;
      irq_set = 1'b0;
      // Transmit holding byte
      if (st_ff.tx_full && tx_ready) begin
         nxt_st.tx_full = 1'b0;
      end
      if (wr && io_addr == `HRP_OFF_TXDATA && !st_ff.tx_full) begin
         nxt_st.tx_full = 1'b1;
         nxt_st.tx_data = io_wdata;
      end
      // Status register, refilled only once empty
      if (rd && io_addr == `HRP_OFF_STATUS) begin
         nxt_st.stat_full = 1'b0;
      end
      if (!st_ff.stat_full && stat_valid) begin
         nxt_st.stat_full = 1'b1;
         nxt_st.stat_data = stat_data;
      end
      // Programmed receive read only while DMA is idle
      if (rd && io_addr == `HRP_OFF_RXDATA && st_ff.dma == hrp_pkg::hrp_dma_idle) begin
         nxt_st.rx_full = 1'b0;
      end
      // Receive DMA
      if (st_ff.dma == hrp_pkg::hrp_dma_run) begin
         if (st_ff.dma_valid && dma_ready) begin
            nxt_st.dma_valid = 1'b0;
            nxt_st.dma_cnt = st_ff.dma_cnt - 16'h0001;
            if (dma_end) begin
               nxt_st.dma = hrp_pkg::hrp_dma_idle;
               nxt_st.dma_done = 1'b1;
            end
         end else if (!st_ff.dma_valid && st_ff.dma_cnt == `HRP_CNT_RST) begin
            nxt_st.dma = hrp_pkg::hrp_dma_idle;
            nxt_st.dma_done = 1'b1;
         end else if (!st_ff.dma_valid && st_ff.rx_full) begin
            nxt_st.dma_valid = 1'b1;
            nxt_st.dma_out = st_ff.rx_byte;
            nxt_st.rx_full = 1'b0;
         end
      end
      // Refill from the FIFO when the register sits empty
      if (!st_ff.rx_full && fifo_valid) begin
         nxt_st.rx_full = 1'b1;
         nxt_st.rx_byte = fifo_byte;
         fifo_pop = 1'b1;
      end
      // Host reads
      if (rd) begin
         case (io_addr)
            `HRP_OFF_RXDATA: nxt_st.rdata = st_ff.rx_byte.data;
            `HRP_OFF_ISR: nxt_st.rdata = isr;
            `HRP_OFF_STATUS: nxt_st.rdata = st_ff.stat_data;
            default: nxt_st.rdata = `HRP_BYTE_RST;
         endcase
      end
      // Interrupt sources by enabled code
      case (st_ff.ier_code)
         `HRP_CODE_STAT_FULL: irq_set = st_ff.stat_full;
         `HRP_CODE_STAT_PEND: irq_set = ~stat_pend_n;
         `HRP_CODE_RX_FULL: irq_set = st_ff.rx_full;
         `HRP_CODE_RX_PEND: irq_set = ~rx_pend_n;
         `HRP_CODE_TX_EMPTY: irq_set = ~st_ff.tx_full;
         `HRP_CODE_TDMA: irq_set = tx_dma_done;
         `HRP_CODE_RDMA: irq_set = st_ff.dma_done;
         default: irq_set = 1'b0;
      endcase
      nxt_st.irq = st_ff.irq | irq_set;
      // A new code replaces the old enable; only code zero drops the latch
      if (wr && io_addr == `HRP_OFF_IER) begin
         nxt_st.ier_code = io_wdata[2:0];
         if (io_wdata[2:0] == `HRP_CODE_OFF) begin
            nxt_st.irq = 1'b0;
         end
         if (io_wdata[2:0] == `HRP_CODE_TDMA) begin
            nxt_st.tx_dma_start = 1'b1;
         end
         if (io_wdata[2:0] == `HRP_CODE_RDMA) begin
            nxt_st.dma = hrp_pkg::hrp_dma_run;
            nxt_st.dma_cnt = rx_dma_count;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign io_rdata = st_ff.rdata;
   assign irq = st_ff.irq;
   assign status_busy = st_ff.stat_full;
   assign tx_valid = st_ff.tx_full;
   assign tx_data = st_ff.tx_data;
   assign tx_dma_start = st_ff.tx_dma_start;
   assign dma_valid = st_ff.dma_valid;
   assign dma_byte = st_ff.dma_out;

   logic rd_isr;
   assign rd_isr = rd && io_addr == `HRP_OFF_ISR;

   property p_isr_value;
      @(posedge clock) disable iff (!arst_n)
      rd_isr |=> io_rdata == {3'h0, $past(st_ff.tx_full), $past(rx_pend_n),
                              $past(st_ff.rx_full), $past(stat_pend_n), $past(st_ff.stat_full)};
   endproperty
   a_isr_value: assert property (p_isr_value) else $error("isr read value wrong");

   property p_rsvd;
      @(posedge clock) disable iff (!arst_n)
      rd_isr |=> io_rdata[7:5] == 3'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

   property p_tx_slot_flag;
      @(posedge clock) disable iff (!arst_n)
      rd_isr |=> io_rdata[`HRP_BIT_TX_EMPTY_N] == $past(tx_valid);
   endproperty
   a_tx_slot_flag: assert property (p_tx_slot_flag) else $error("transmit flag wrong");

   property p_frame_flag_idle;
      @(posedge clock) disable iff (!arst_n)
      rd_isr && !st_ff.rx_full && !fifo_valid |=> io_rdata[`HRP_BIT_RX_PEND_N];
   endproperty
   a_frame_flag_idle: assert property (p_frame_flag_idle) else $error("frame flag low idle");

   property p_frame_flag_busy;
      @(posedge clock) disable iff (!arst_n)
      rd_isr && st_ff.rx_full |=> !io_rdata[`HRP_BIT_RX_PEND_N] && io_rdata[`HRP_BIT_RX_FULL];
   endproperty
   a_frame_flag_busy: assert property (p_frame_flag_busy) else $error("frame flag high");

   property p_status_flags;
      @(posedge clock) disable iff (!arst_n)
      rd_isr && status_busy
         |=> !io_rdata[`HRP_BIT_STAT_PEND_N] && io_rdata[`HRP_BIT_STAT_FULL];
   endproperty
   a_status_flags: assert property (p_status_flags) else $error("status flags wrong");

   property p_status_clear;
      @(posedge clock) disable iff (!arst_n)
      rd && io_addr == `HRP_OFF_STATUS && status_busy |=> !status_busy;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status read kept full");

   property p_rdma_start;
      @(posedge clock) disable iff (!arst_n)
      wr && io_addr == `HRP_OFF_IER && io_wdata[2:0] == 3'h7
         |=> st_ff.dma == hrp_pkg::hrp_dma_run && st_ff.ier_code == 3'h7;
   endproperty
   a_rdma_start: assert property (p_rdma_start) else $error("receive dma not started");

   property p_irq_hold;
      @(posedge clock) disable iff (!arst_n)
      irq && !(wr && io_addr == `HRP_OFF_IER && io_wdata[2:0] == 3'h0) |=> irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");

   property p_irq_clear;
      @(posedge clock) disable iff (!arst_n)
      wr && io_addr == `HRP_OFF_IER && io_wdata[2:0] == 3'h0 |=> !irq;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");

   property p_dma_move;
      @(posedge clock) disable iff (!arst_n)
      st_ff.dma == hrp_pkg::hrp_dma_run && !dma_valid && st_ff.rx_full && st_ff.dma_cnt != 16'h0
         |=> dma_valid && dma_byte == $past(st_ff.rx_byte);
   endproperty
   a_dma_move: assert property (p_dma_move) else $error("dma byte not presented");

   property p_dma_done;
      @(posedge clock) disable iff (!arst_n)
      dma_end && st_ff.ier_code == 3'h7 && !wr
         |=> st_ff.dma == hrp_pkg::hrp_dma_idle ##1 irq;
   endproperty
   a_dma_done: assert property (p_dma_done) else $error("dma end not signalled");
endmodule

// ### dv/hrp_host.sv
// Purpose: Host processor model on the card's byte I/O port
// Assumes: One-cycle strobes, read data valid after the read edge
// Notes: Released write data is inverted so stale values never match
`timescale 1ns/100ps
module hrp_host (
   // Clock
   input wire logic clock,
   // Host I/O port
   output logic io_cs,
   output logic io_rd,
   output logic io_wr,
   output logic [3:0] io_addr,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata
);
   initial begin
      io_cs = 1'b0;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_addr = 4'h0;
      io_wdata = 8'h00;
   end
   // Byte writes only; transmit data and enable codes alike, no flag polling
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      io_cs <= 1'b1;
      io_wr <= 1'b1;
      io_addr <= a;
      io_wdata <= d;
      @(posedge clock);
      io_cs <= 1'b0;
      io_wr <= 1'b0;
      io_wdata <= ~d;
   endtask
   // Flag, status and receive bytes are fetched by programmed reads
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      io_cs <= 1'b1;
      io_rd <= 1'b1;
      io_addr <= a;
      @(posedge clock);
      io_cs <= 1'b0;
      io_rd <= 1'b0;
      #1;
      d = io_rdata;
   endtask
endmodule

// ### dv/hrp_port_tb.sv
// Purpose: Self-checking bench for the host data and flag status port
// Assumes: FIFO depth cut to 4 so fill and drain stay short
// Notes: Expected flag bytes are built by hand from the bit layout
`timescale 1ns/100ps
module hrp_port_tb;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic net_valid = 1'b0;
   hrp_pkg::hrp_byte_t net_byte = '0;
   logic stat_valid = 1'b0;
   logic [7:0] stat_data = 8'h00;
   logic tx_ready = 1'b0;
   logic tx_dma_done = 1'b0;
   logic [15:0] rx_dma_count = 16'h0000;
   logic dma_ready = 1'b0;
   logic io_cs, io_rd, io_wr, irq, net_ready, status_busy, tx_valid, tx_dma_start, dma_valid;
   logic [3:0] io_addr;
   logic [7:0] io_wdata, io_rdata, tx_data, got;
   hrp_pkg::hrp_byte_t dma_byte;
   logic [8:0] dq[$];
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   always #50 clock = ~clock;
   hrp_port #(.FIFO_DEPTH(4)) uut (.clock(clock), .arst_n(arst_n), .io_cs(io_cs),
      .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
      .io_rdata(io_rdata), .irq(irq), .net_valid(net_valid), .net_byte(net_byte),
      .net_ready(net_ready), .stat_valid(stat_valid), .stat_data(stat_data),
      .status_busy(status_busy), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .tx_dma_start(tx_dma_start), .tx_dma_done(tx_dma_done),
      .rx_dma_count(rx_dma_count), .dma_valid(dma_valid), .dma_byte(dma_byte),
      .dma_ready(dma_ready));
   hrp_host host (.clock(clock), .io_cs(io_cs), .io_rd(io_rd), .io_wr(io_wr),
      .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata));
   // Capture every byte the DMA stream hands over
   always @(posedge clock) begin
      if (dma_valid === 1'b1 && dma_ready === 1'b1) begin
         dq.push_back(dma_byte);
      end
   end
   // Hang guard, far above the fewer than two hundred cycles the run needs
   always @(posedge clock) begin
      cyc++;
      if (cyc == 8000) begin
         err_count++;
         finish_test();
      end
   end
   task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic isr(input logic [7:0] e);
      host.rd(4'h5, got);
      chk("flag status", {1'b0, e}, {1'b0, got});
   endtask
   task automatic push(input logic [7:0] d, input logic l);
      @(posedge clock);
      net_valid <= 1'b1;
      net_byte <= {d, l};
      @(posedge clock);
      net_valid <= 1'b0;
      net_byte <= {~d, ~l};
   endtask
   task automatic wait_irq;
      int k;
      k = 0;
      while (irq !== 1'b1 && k < 100) begin
         @(posedge clock);
         #1;
         k++;
      end
   endtask
   task automatic t_idle;
      isr(8'h0A);
      host.rd(4'h0, got);
      chk("unmapped read", 9'h000, {1'b0, got});
   endtask
   task automatic t_status;
      @(posedge clock);
      stat_valid <= 1'b1;
      stat_data <= 8'hA5;
      @(posedge clock);
      stat_valid <= 1'b0;
      stat_data <= 8'h5A;
      repeat (2) @(posedge clock);
      isr(8'h09);
      chk("status busy", 9'h001, {8'h00, status_busy});
      host.rd(4'h1, got);
      chk("status byte", 9'h0A5, {1'b0, got});
      isr(8'h0A);
      chk("status idle", 9'h000, {8'h00, status_busy});
   endtask
   task automatic t_tx;
      host.wr(4'h2, 8'h3C);
      host.wr(4'h2, 8'hC3);
      isr(8'h1A);
      chk("tx byte kept", 9'h03C, {1'b0, tx_data});
      chk("tx held", 9'h001, {8'h00, tx_valid});
      tx_ready <= 1'b1;
      @(posedge clock);
      tx_ready <= 1'b0;
      isr(8'h0A);
   endtask
   task automatic t_rx;
      push(8'h77, 1'b1);
      repeat (3) @(posedge clock);
      isr(8'h06);
      host.rd(4'h3, got);
      chk("rx byte", 9'h077, {1'b0, got});
      isr(8'h0A);
   endtask
   // Fill FIFO and data register until refused, then drain by DMA once dma_ready rises
   task automatic t_fill_dma;
      int n;
      logic a;
      n = 0;
      @(posedge clock);
      net_valid <= 1'b1;
      net_byte <= 9'h000;
      repeat (14) begin
         @(negedge clock);
         a = net_ready;
         @(posedge clock);
         n += int'(a);
         net_byte <= {8'(n), n == 4};
      end
      net_valid <= 1'b0;
      chk("bytes taken", 9'd5, 9'(n));
      isr(8'h06);
      dq.delete();
      rx_dma_count <= 16'h0010;
      host.wr(4'h8, 8'h07);
      repeat (6) @(posedge clock);
      chk("dma offered", 9'h001, {8'h00, dma_valid});
      dma_ready <= 1'b1;
      wait_irq();
      chk("irq frame end", 9'h001, {8'h00, irq});
      chk("dma count", 9'd5, 9'(dq.size()));
      for (int i = 0; i < 5; i++) begin
         chk("dma byte", {8'(i), i == 4}, dq[i]);
      end
      // Code 1 condition is false here, so only the latch keeps irq up
      host.wr(4'h8, 8'h01);
      repeat (3) @(posedge clock);
      chk("irq latched", 9'h001, {8'h00, irq});
      host.wr(4'h8, 8'h00);
      repeat (3) @(posedge clock);
      chk("irq cleared", 9'h000, {8'h00, irq});
   endtask
   task automatic t_count;
      push(8'hA1, 1'b0);
      push(8'hA2, 1'b0);
      push(8'hA3, 1'b1);
      dq.delete();
      rx_dma_count <= 16'h0002;
      host.wr(4'h8, 8'h07);
      wait_irq();
      chk("irq count zero", 9'h001, {8'h00, irq});
      chk("dma count", 9'd2, 9'(dq.size()));
      chk("dma last", {8'hA2, 1'b0}, dq[1]);
      host.wr(4'h8, 8'h00);
      dma_ready <= 1'b0;
      host.rd(4'h3, got);
      chk("leftover byte", 9'h0A3, {1'b0, got});
   endtask
   // Code 6 start pulse and done latch, then code 4 on a new frame
   task automatic t_codes;
      host.wr(4'h8, 8'h06);
      @(negedge clock);
      chk("tx dma start", 9'h001, {8'h00, tx_dma_start});
      chk("irq before done", 9'h000, {8'h00, irq});
      @(posedge clock);
      tx_dma_done <= 1'b1;
      @(posedge clock);
      tx_dma_done <= 1'b0;
      wait_irq();
      chk("irq tx done", 9'h001, {8'h00, irq});
      chk("tx dma start end", 9'h000, {8'h00, tx_dma_start});
      host.wr(4'h8, 8'h00);
      host.wr(4'h8, 8'h04);
      repeat (3) @(posedge clock);
      chk("irq no frame", 9'h000, {8'h00, irq});
      push(8'h5E, 1'b1);
      wait_irq();
      chk("irq frame", 9'h001, {8'h00, irq});
      host.wr(4'h8, 8'h00);
      host.rd(4'h3, got);
      chk("frame byte", 9'h05E, {1'b0, got});
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      t_idle();
      t_status();
      t_tx();
      t_rx();
      t_fill_dma();
      t_count();
      t_codes();
      finish_test();
   end
endmodule
